// *** hw/dio_exp.sv ***
// Sixteen-line port expander reached over the serial link.
`timescale 1ns/1ps
module dio_exp (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	dio_ser_if.exp           ser,
	input  wire logic [15:0] pin_in,
	output logic      [15:0] pin_out,
	output logic      [15:0] pin_oe_n_out
);
	import dio_pkg::*;

	logic [15:0] dir_q, dir_d, pol_q, pol_d, inten_q, inten_d, open_q, open_d;
	logic [15:0] latch_q, latch_d, flag_q, flag_d, cap_q, cap_d, prev_q, prev_d;
	logic [7:0]  cfg_q, cfg_d, rd_q, rd_d;
	logic [23:0] sh_q, sh_d;
	logic [4:0]  cnt_q, cnt_d;
	logic        sclk_q;
	logic [15:0] chg, clr, seen;
	logic [7:0]  rdv;
	logic        rise, fall;

	// ----------------------------------------------------------------
	// Serial slave, register file and change detection.
	// ----------------------------------------------------------------
	// Modes 00 and 11: data in on the rising edge, out on the falling edge.
	always_comb
	begin
		dir_d   = dir_q;
		pol_d   = pol_q;
		inten_d = inten_q;
		open_d  = open_q;
		latch_d = latch_q;
		cfg_d   = cfg_q;
		cap_d   = cap_q;
		rd_d    = rd_q;
		sh_d    = sh_q;
		cnt_d   = cnt_q;
		clr     = 16'h0000;
		rdv     = 8'h00;
		rise    = ser.sclk & ~sclk_q;
		fall    = ~ser.sclk & sclk_q;
		prev_d  = pin_in;
		seen    = pin_in ^ pol_q;
		chg     = (pin_in ^ prev_q) & inten_q & dir_q;
		if (ser.sel_n)
		begin
			cnt_d = 5'h00;
		end
		else if (rise && cnt_q != EXP_FRAME_BITS)
		begin
			sh_d  = {sh_q[22:0], ser.mosi};
			cnt_d = cnt_q + 5'h01;
			if (cnt_d == EXP_HEAD_BITS && sh_d[15:9] == EXP_OPCODE && sh_d[7:5] == 3'h0)
			begin
				// Paged register read selected by the address byte.
				unique case (sh_d[4:1])
					EXP_K_DIR:     rdv = dir_q[{sh_d[0], 3'h0} +: 8];
					EXP_K_POL:     rdv = pol_q[{sh_d[0], 3'h0} +: 8];
					EXP_K_INTEN:   rdv = inten_q[{sh_d[0], 3'h0} +: 8];
					EXP_K_OPEN:    rdv = open_q[{sh_d[0], 3'h0} +: 8];
					EXP_K_CONFIG:  rdv = cfg_q;
					EXP_K_FLAG:    rdv = flag_q[{sh_d[0], 3'h0} +: 8];
					EXP_K_CAPTURE: rdv = cap_q[{sh_d[0], 3'h0} +: 8];
					EXP_K_PORT:    rdv = seen[{sh_d[0], 3'h0} +: 8];
					EXP_K_LATCH:   rdv = latch_q[{sh_d[0], 3'h0} +: 8];
					default:       rdv = 8'h00;
				endcase
				if (sh_d[8])
				begin
					rd_d = rdv;
					if (sh_d[4:1] == EXP_K_CAPTURE || sh_d[4:1] == EXP_K_PORT)
						clr[{sh_d[0], 3'h0} +: 8] = 8'hff;
				end
			end
			if (cnt_d == EXP_FRAME_BITS && sh_d[23:17] == EXP_OPCODE && !sh_d[16] && sh_d[15:13] == 3'h0)
			begin
				unique case (sh_d[12:9])
					EXP_K_DIR:   dir_d[{sh_d[8], 3'h0} +: 8] = sh_d[7:0];
					EXP_K_POL:   pol_d[{sh_d[8], 3'h0} +: 8] = sh_d[7:0];
					EXP_K_INTEN: inten_d[{sh_d[8], 3'h0} +: 8] = sh_d[7:0];
					EXP_K_OPEN:  open_d[{sh_d[8], 3'h0} +: 8] = sh_d[7:0];
					EXP_K_CONFIG: cfg_d = sh_d[7:0];
					EXP_K_PORT, EXP_K_LATCH: latch_d[{sh_d[8], 3'h0} +: 8] = sh_d[7:0];
					default: cfg_d = cfg_q;
				endcase
			end
		end
		else if (fall && cnt_q > EXP_HEAD_BITS)
		begin
			rd_d = {rd_q[6:0], 1'b0};
		end
		// A change in the same cycle as a clearing read still leaves its flag set.
		flag_d = (flag_q & ~clr) | chg;
		if (|chg[7:0])
			cap_d[7:0] = pin_in[7:0];
		if (|chg[15:8])
			cap_d[15:8] = pin_in[15:8];
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			dir_q   <= EXP_DIR_RESET;
			pol_q   <= 16'h0000;
			inten_q <= 16'h0000;
			open_q  <= 16'h0000;
			latch_q <= 16'h0000;
			flag_q  <= 16'h0000;
			cap_q   <= 16'h0000;
			prev_q  <= 16'h0000;
			cfg_q   <= 8'h00;
			rd_q    <= 8'h00;
			sh_q    <= 24'h000000;
			cnt_q   <= 5'h00;
			sclk_q  <= 1'b0;
		end
		else
		begin
			dir_q   <= dir_d;
			pol_q   <= pol_d;
			inten_q <= inten_d;
			open_q  <= open_d;
			latch_q <= latch_d;
			flag_q  <= flag_d;
			cap_q   <= cap_d;
			prev_q  <= prev_d;
			cfg_q   <= cfg_d;
			rd_q    <= rd_d;
			sh_q    <= sh_d;
			cnt_q   <= cnt_d;
			sclk_q  <= ser.sclk;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers and interrupt pin.
	// ----------------------------------------------------------------
	// An open-drain line only drives while its latch holds zero.
	assign pin_out      = latch_q & ~open_q;
	assign pin_oe_n_out = dir_q | (open_q & latch_q);
	assign ser.miso     = (!ser.sel_n && cnt_q >= EXP_HEAD_BITS) ? rd_q[7] : 1'b0;
	// Only the first port's pin reaches the board; mirroring folds the second one in.
	assign ser.int_act  = (|flag_q[7:0]) | (cfg_q[CFG_MIRROR_BIT] & (|flag_q[15:8]));
	assign ser.int_od   = cfg_q[CFG_OD_INT_BIT];

endmodule

// *** hw/dio_pkg.sv ***
// Shared constants, field layouts and types for the serial-attached digital I/O block.
package dio_pkg;

	// ----------------------------------------------------------------
	// Host register addresses (I/O space).
	// ----------------------------------------------------------------
	localparam logic [9:0] ADDR_CONTROL   = 10'h1d8;
	localparam logic [9:0] ADDR_STATUS    = 10'h1d9;
	localparam logic [9:0] ADDR_BYTE_ZERO = 10'h1da;
	localparam logic [9:0] ADDR_BYTE_ONE  = 10'h1db;
	localparam logic [9:0] ADDR_BYTE_TWO  = 10'h1dc;
	localparam logic [9:0] ADDR_BYTE_TOP  = 10'h1dd;

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int unsigned CTL_SEL_LSB      = 0;
	localparam int unsigned CTL_MAN_BIT      = 3;
	localparam int unsigned CTL_LEN_LSB      = 4;
	localparam int unsigned CTL_CPHA_BIT     = 6;
	localparam int unsigned CTL_CPOL_BIT     = 7;
	localparam int unsigned ST_BUSY_BIT      = 0;
	localparam int unsigned ST_LSB_FIRST_BIT = 1;
	localparam int unsigned ST_IRQ_LSB       = 2;
	localparam int unsigned ST_SPEED_LSB     = 4;
	localparam int unsigned ST_IRQ_PEND_BIT  = 7;
	localparam logic [7:0]  CONTROL_RESET    = 8'h00;
	localparam logic [4:0]  STATUS_CFG_RESET = 5'h00;
	localparam logic [2:0]  SEL_FIRST_EXP    = 3'h6;
	localparam logic [2:0]  SEL_SECOND_EXP   = 3'h7;
	localparam int unsigned NUM_IRQ_LINES    = 3;

	// ----------------------------------------------------------------
	// Serial clock timing: half periods for speed codes 0..3 (1, 2, 4, 8 MHz).
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS    = 10000;
	localparam int unsigned SCLK_HALF_PS [4] = '{500000, 250000, 125000, 62500};
	localparam int unsigned SCLK_HALF_CYC [4] = '{
		(SCLK_HALF_PS[0] + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
		(SCLK_HALF_PS[1] + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
		(SCLK_HALF_PS[2] + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS,
		(SCLK_HALF_PS[3] + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS};

	// ----------------------------------------------------------------
	// Expander opcodes, register kinds (address bits 4:1) and config bits.
	// ----------------------------------------------------------------
	localparam logic [6:0]  EXP_OPCODE      = 7'h20;
	localparam int unsigned EXP_LINES       = 16;
	localparam logic [15:0] EXP_DIR_RESET   = 16'hffff;
	localparam logic [3:0]  EXP_K_DIR       = 4'h0;
	localparam logic [3:0]  EXP_K_POL       = 4'h1;
	localparam logic [3:0]  EXP_K_INTEN     = 4'h2;
	localparam logic [3:0]  EXP_K_OPEN      = 4'h3;
	localparam logic [3:0]  EXP_K_CONFIG    = 4'h5;
	localparam logic [3:0]  EXP_K_FLAG      = 4'h7;
	localparam logic [3:0]  EXP_K_CAPTURE   = 4'h8;
	localparam logic [3:0]  EXP_K_PORT      = 4'h9;
	localparam logic [3:0]  EXP_K_LATCH     = 4'ha;
	localparam int unsigned CFG_OD_INT_BIT  = 2;
	localparam int unsigned CFG_MIRROR_BIT  = 6;
	localparam logic [4:0]  EXP_FRAME_BITS  = 5'h18;
	localparam logic [4:0]  EXP_HEAD_BITS   = 5'h10;

	typedef enum logic [3:0] {
		DIO_IDLE    = 4'b0001,
		DIO_SETUP   = 4'b0010,
		DIO_RUN     = 4'b0100,
		DIO_RELEASE = 4'b1000
	} dio_state_t;

endpackage

// *** hw/dio_ser_if.sv ***
// Serial link and interrupt wiring between the frame engine and one expander.
`timescale 1ns/1ps
interface dio_ser_if;
	logic sclk;
	logic mosi;
	logic sel_n;
	logic miso;
	logic int_act;
	logic int_od;
	modport ctl (output sclk, output mosi, output sel_n, input miso, input int_act, input int_od);
	modport exp (input sclk, input mosi, input sel_n, output miso, output int_act, output int_od);
endinterface

// *** hw/dio_top.sv ***
// Serial frame engine, host registers and two port expanders forming 32 digital lines.
// Contract
// - Thirty-two lines as four eight-bit bidirectional ports.
// - Software selects direction and push-pull/open-drain per line.
// - Optional per-line inversion of input data.
// - Any level change on an input line may interrupt.
// - Select code 6 reaches channels 0 to 15.
// - Select code 7 reaches channels 16 to 31.
// - Each port pair has paged serial configuration registers.
// - Status picks the interrupt line, shared by devices.
// - Shared line also serves stacked bus, needs enable.
// - Poll status bit 0 until zero between frames.
// - Top byte write starts clock, auto asserts select.
`timescale 1ns/1ps
module dio_top #(
	parameter int unsigned LINES = 32
) (
	input  wire logic                                sys_clk_in,
	input  wire logic                                rst_in,
	input  wire logic [9:0]                          io_addr_in,
	input  wire logic                                io_wr_in,
	input  wire logic                                io_rd_in,
	input  wire logic [7:0]                          io_wdata_in,
	output logic      [7:0]                          io_rdata_out,
	input  wire logic [LINES-1:0]                    dio_in,
	output logic      [LINES-1:0]                    dio_out,
	output logic      [LINES-1:0]                    dio_oe_n_out,
	output logic                                     spi_sclk_out,
	output logic                                     spi_mosi_out,
	input  wire logic                                spi_miso_in,
	output logic      [7:0]                          spi_select_n_out,
	input  wire logic                                ext_irq_n_in,
	input  wire logic                                bus_irq_enable_in,
	output logic      [dio_pkg::NUM_IRQ_LINES-1:0]   irq_out
);
	import dio_pkg::*;

	// Two expanders of sixteen lines each are all the wiring can serve.
	if (LINES != 2 * EXP_LINES)
	begin : g_width_check
		$error("dio_top: LINES must be twice the expander width");
	end

	dio_ser_if ser0 ();
	dio_ser_if ser1 ();

	dio_state_t  state_q, state_d;
	logic [7:0]  control_q, control_d, rdata_q, rdata_d;
	logic [4:0]  stcfg_q, stcfg_d;
	logic [31:0] word_q, word_d;
	logic [2:0]  sel_q, sel_d;
	logic [5:0]  div_q, div_d, edge_q, edge_d;
	logic        sclk_q, sclk_d, rx_q, rx_d;
	logic [NUM_IRQ_LINES-1:0] irq_q, irq_d;
	logic        busy, tick, cpha, cpol, lsb_first, sel_active, miso, shared_irq;
	logic [1:0]  len;
	logic [2:0]  sel_now;
	logic [5:0]  half_m1, last_edge;

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	// Moves the frame one bit; bytes below the programmed length stay untouched.
	function automatic logic [31:0] shift_word(input logic [31:0] w, input logic [1:0] fl, input logic lsb,
		input logic rx);
		logic [31:0] r;
		logic [31:0] sr;
		logic [31:0] sl;
		int          lo;
		r  = w;
		sr = w >> 1;
		sl = w << 1;
		lo = (3 - int'(fl)) * 8;
		for (int i = 0; i < 32; i++)
		begin
			if (i >= lo)
				r[i] = lsb ? ((i == 31) ? rx : sr[i]) : ((i == lo) ? rx : sl[i]);
		end
		return r;
	endfunction

	assign busy       = (state_q != DIO_IDLE);
	assign cpha       = control_q[CTL_CPHA_BIT];
	assign cpol       = control_q[CTL_CPOL_BIT];
	assign len        = control_q[CTL_LEN_LSB +: 2];
	assign lsb_first  = stcfg_q[ST_LSB_FIRST_BIT - 1];
	assign half_m1    = 6'(SCLK_HALF_CYC[stcfg_q[ST_SPEED_LSB - 1 +: 2]] - 1);
	assign last_edge  = {len, 4'hf};                                // Two edges per bit, counted from zero.
	assign tick       = busy && (div_q == 6'h00);
	// Manual mode holds the chosen select for as long as software keeps the bit set.
	assign sel_now    = control_q[CTL_MAN_BIT] ? control_q[CTL_SEL_LSB +: 3] : sel_q;
	assign sel_active = control_q[CTL_MAN_BIT] | busy;

	// ----------------------------------------------------------------
	// Host registers and frame engine.
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d   = state_q;
		control_d = control_q;
		stcfg_d   = stcfg_q;
		word_d    = word_q;
		sel_d     = sel_q;
		sclk_d    = sclk_q;
		rx_d      = rx_q;
		edge_d    = edge_q;
		rdata_d   = rdata_q;
		div_d     = (busy && div_q != 6'h00) ? div_q - 6'h01 : half_m1;
		// Host writes; frame contents and control are frozen while a frame runs, status is written at any time.
		if (io_wr_in)
		begin
			if (io_addr_in == ADDR_STATUS)
				stcfg_d = io_wdata_in[5:1];
			else if (!busy)
			begin
				unique case (io_addr_in)
					ADDR_CONTROL:   control_d = io_wdata_in;
					ADDR_BYTE_ZERO: word_d[7:0]   = io_wdata_in;
					ADDR_BYTE_ONE:  word_d[15:8]  = io_wdata_in;
					ADDR_BYTE_TWO:  word_d[23:16] = io_wdata_in;
					ADDR_BYTE_TOP:
					begin
						word_d[31:24] = io_wdata_in;
						state_d       = DIO_SETUP;
						sel_d         = control_q[CTL_SEL_LSB +: 3];
						sclk_d        = cpol;
						edge_d        = 6'h00;
						div_d         = half_m1;
					end
					default: word_d = word_q;
				endcase
			end
		end
		unique case (state_q)
			DIO_IDLE:  sclk_d = (state_d == DIO_SETUP) ? cpol : sclk_q;
			DIO_SETUP:
			begin
				if (tick)
				begin
					state_d = DIO_RUN;
				end
			end
			DIO_RUN:
			begin
				if (tick)
				begin
					sclk_d = ~sclk_q;
					edge_d = edge_q + 6'h01;
					if (edge_q[0] == cpha)
						rx_d = miso;
					else if (!(cpha && edge_q == 6'h00))
						word_d = shift_word(word_q, len, lsb_first, rx_q);
					if (edge_q == last_edge)
						state_d = DIO_RELEASE;
				end
			end
			DIO_RELEASE:
			begin
				if (tick)
				begin
					// Trailing-phase modes still owe the last bit's move.
					if (cpha)
						word_d = shift_word(word_q, len, lsb_first, rx_q);
					state_d = DIO_IDLE;
				end
			end
		endcase
		// Host reads return received data and live state.
		if (io_rd_in)
		begin
			unique case (io_addr_in)
				ADDR_CONTROL:   rdata_d = control_q;
				ADDR_STATUS:    rdata_d = {shared_irq, 1'b0, stcfg_q, busy};
				ADDR_BYTE_ZERO: rdata_d = word_q[7:0];
				ADDR_BYTE_ONE:  rdata_d = word_q[15:8];
				ADDR_BYTE_TWO:  rdata_d = word_q[23:16];
				ADDR_BYTE_TOP:  rdata_d = word_q[31:24];
				default:        rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_q   <= DIO_IDLE;
			control_q <= CONTROL_RESET;
			stcfg_q   <= STATUS_CFG_RESET;
			word_q    <= 32'h00000000;
			sel_q     <= 3'h0;
			div_q     <= 6'h00;
			edge_q    <= 6'h00;
			sclk_q    <= 1'b0;
			rx_q      <= 1'b0;
			rdata_q   <= 8'h00;
		end
		else
		begin
			state_q   <= state_d;
			control_q <= control_d;
			stcfg_q   <= stcfg_d;
			word_q    <= word_d;
			sel_q     <= sel_d;
			div_q     <= div_d;
			edge_q    <= edge_d;
			sclk_q    <= (state_d == DIO_IDLE) ? cpol : sclk_d;
			rx_q      <= rx_d;
			rdata_q   <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Serial pins, select routing and expanders.
	// ----------------------------------------------------------------
	assign miso = (sel_q == SEL_FIRST_EXP) ? ser0.miso : (sel_q == SEL_SECOND_EXP) ? ser1.miso : spi_miso_in;
	assign spi_sclk_out = sclk_q;
	assign spi_mosi_out = lsb_first ? word_q[{~len, 3'h0}] : word_q[31];
	always_comb
	begin
		for (int k = 0; k < 8; k++)
			spi_select_n_out[k] = !(sel_active && sel_now == 3'(k));
	end
	assign ser0.sclk  = sclk_q;
	assign ser0.mosi  = spi_mosi_out;
	assign ser0.sel_n = spi_select_n_out[SEL_FIRST_EXP];
	assign ser1.sclk  = sclk_q;
	assign ser1.mosi  = spi_mosi_out;
	assign ser1.sel_n = spi_select_n_out[SEL_SECOND_EXP];

	// Channels 0..15 sit on the first expander, 16..31 on the second.
	dio_exp u_exp_lo (
		.sys_clk_in   (sys_clk_in),
		.rst_in       (rst_in),
		.ser          (ser0.exp),
		.pin_in       (dio_in[15:0]),
		.pin_out      (dio_out[15:0]),
		.pin_oe_n_out (dio_oe_n_out[15:0])
	);
	dio_exp u_exp_hi (
		.sys_clk_in   (sys_clk_in),
		.rst_in       (rst_in),
		.ser          (ser1.exp),
		.pin_in       (dio_in[31:16]),
		.pin_out      (dio_out[31:16]),
		.pin_oe_n_out (dio_oe_n_out[31:16])
	);

	// ----------------------------------------------------------------
	// Shared interrupt line.
	// ----------------------------------------------------------------
	// A push-pull expander pin that is idle holds the wired line high and hides
	// every other source, which is why both expanders must be set open-drain.
	assign shared_irq = ((ser0.int_act | ser1.int_act | ~ext_irq_n_in)
		& ~((~ser0.int_act & ~ser0.int_od) | (~ser1.int_act & ~ser1.int_od)));
	always_comb
	begin
		for (int k = 0; k < NUM_IRQ_LINES; k++)
			irq_d[k] = shared_irq && bus_irq_enable_in
				&& (stcfg_q[ST_IRQ_LSB - 1 +: 2] == 2'(k + 1));
	end
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			irq_q <= '0;
		else
			irq_q <= irq_d;
	end
	assign irq_out      = irq_q;
	assign io_rdata_out = rdata_q;

endmodule

// *** verif/dio_field.sv ***
// External circuits on the thirty-two lines and the idle off-board serial slave.
`timescale 1ns/1ps
module dio_field (
	input  wire logic        sys_clk_in,
	input  wire logic [31:0] dio_out_in,
	input  wire logic [31:0] dio_oe_n_in,
	input  wire logic [31:0] ext_level_in,
	output logic      [31:0] dio_level_out,
	output logic             miso_out
);
	// A driven line shows the block's value; a released one shows the outside level.
	always_comb dio_level_out = (dio_out_in & ~dio_oe_n_in) | (ext_level_in & dio_oe_n_in);

	// No off-board slave answers a select, so the data line toggles instead of holding a stale bit.
	initial miso_out = 1'b0;
	always @(posedge sys_clk_in) miso_out <= ~miso_out;
endmodule

// *** verif/dio_top_sva.sv ***
// Port-level assertions for the serial digital I/O block.
`timescale 1ns/1ps
module dio_top_sva
	import dio_pkg::*;
#(
	parameter int unsigned LINES = 32
) (
	input wire logic                              sys_clk_in,
	input wire logic                              rst_in,
	input wire logic [9:0]                        io_addr_in,
	input wire logic                              io_wr_in,
	input wire logic                              io_rd_in,
	input wire logic [7:0]                        io_rdata_out,
	input wire logic                              spi_sclk_out,
	input wire logic [7:0]                        spi_select_n_out,
	input wire logic                              bus_irq_enable_in,
	input wire logic [dio_pkg::NUM_IRQ_LINES-1:0] irq_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	// No select low means no frame is running.
	logic idle;
	assign idle = &spi_select_n_out;

	a_one_select: assert property ($onehot0(~spi_select_n_out)) else $error("two selects low");
	// A control write may legally move the idle clock level, so the cycle it lands in is excused.
	a_sclk_still: assert property (idle && $past(idle) && !$past(io_wr_in, 2) |-> $stable(spi_sclk_out))
		else $error("clock moved idle");
	a_launch_sel: assert property (io_wr_in && io_addr_in == ADDR_BYTE_TOP && idle |=> !idle)
		else $error("launch without select");
	a_sclk_lead: assert property (!idle && $past(idle) |-> $stable(spi_sclk_out)[*4]) else $error("early edge");
	a_busy_set: assert property (io_rd_in && io_addr_in == ADDR_STATUS && !idle |=> io_rdata_out[0])
		else $error("busy low in frame");
	a_busy_clear: assert property (io_rd_in && io_addr_in == ADDR_STATUS && idle && $past(idle) |=> !io_rdata_out[0])
		else $error("busy high when idle");
	a_rdata_hold: assert property (!io_rd_in |=> $stable(io_rdata_out)) else $error("read data moved");
	a_irq_gate: assert property (!bus_irq_enable_in [*3] |-> irq_out == '0) else $error("irq without enable");
	a_irq_single: assert property ($onehot0(irq_out)) else $error("several irq lines");

	c_launch: cover property (io_wr_in && io_addr_in == ADDR_BYTE_TOP && idle);
	c_busy: cover property (io_rd_in && io_addr_in == ADDR_STATUS && !idle);
	c_irq: cover property (irq_out[0]);
endmodule

bind dio_top dio_top_sva #(.LINES(LINES)) dio_top_sva_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
	.io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_rdata_out(io_rdata_out),
	.spi_sclk_out(spi_sclk_out), .spi_select_n_out(spi_select_n_out),
	.bus_irq_enable_in(bus_irq_enable_in), .irq_out(irq_out));

// *** verif/tb.sv ***
// Self-checking bench driving the digital I/O block through its host registers.
`timescale 1ns/1ps
module tb;
	import dio_pkg::*;
	logic        sys_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [9:0]  io_addr_in = '0;
	logic        io_wr_in = 1'b0;
	logic        io_rd_in = 1'b0;
	logic [7:0]  io_wdata_in = '0;
	logic        ext_irq_n_in = 1'b1;
	logic        bus_irq_enable_in = 1'b0;
	logic [31:0] ext_level = '1;
	logic [7:0]  io_rdata_out, spi_select_n_out, v;
	logic [31:0] dio_in, dio_out, dio_oe_n_out;
	logic        spi_sclk_out, spi_mosi_out, spi_miso_in;
	logic [2:0]  irq_out;
	int          n_mismatch = 0;
	int          tests_run = 0;

	dio_top #(.LINES(32)) dio_top_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .io_addr_in(io_addr_in),
		.io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
		.dio_in(dio_in), .dio_out(dio_out), .dio_oe_n_out(dio_oe_n_out), .spi_sclk_out(spi_sclk_out),
		.spi_mosi_out(spi_mosi_out), .spi_miso_in(spi_miso_in), .spi_select_n_out(spi_select_n_out),
		.ext_irq_n_in(ext_irq_n_in), .bus_irq_enable_in(bus_irq_enable_in), .irq_out(irq_out));
	dio_field dio_field_i (.sys_clk_in(sys_clk_in), .dio_out_in(dio_out), .dio_oe_n_in(dio_oe_n_out),
		.ext_level_in(ext_level), .dio_level_out(dio_in), .miso_out(spi_miso_in));

	initial
	begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Every host access is a one-cycle strobe launched just after an edge.
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk_in) #1;
		io_addr_in = a;
		io_wdata_in = d;
		io_wr_in = 1'b1;
		@(posedge sys_clk_in) #1;
		io_wr_in = 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge sys_clk_in) #1;
		io_addr_in = a;
		io_rd_in = 1'b1;
		@(posedge sys_clk_in) #1;
		io_rd_in = 1'b0;
		d = io_rdata_out;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask

	// One expander frame; a control write during the frame must be ignored.
	task automatic frame(input logic [7:0] ctl, input logic [7:0] op, input logic [7:0] ra, input logic [7:0] d);
		int n;
		wr(ADDR_CONTROL, ctl);
		wr(ADDR_BYTE_ONE, d);
		wr(ADDR_BYTE_TWO, ra);
		wr(ADDR_BYTE_TOP, op);
		wr(ADDR_CONTROL, 8'h00);
		rd(ADDR_STATUS, v);
		chk8(v & 8'h01, 8'h01);
		n = 0;
		while (v[0] === 1'b1 && n < 400)
		begin
			rd(ADDR_STATUS, v);
			n++;
		end
		chk8(v & 8'h01, 8'h00);
		rd(ADDR_CONTROL, v);
		chk8(v, ctl);
	endtask

	// One byte to an off-board select; the data line is gathered at each rising clock, first bit on top.
	task automatic xmit(input logic [7:0] st, input logic [7:0] d, input logic [7:0] exp);
		logic [7:0] got;
		wr(ADDR_STATUS, st);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_BYTE_TOP, d);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge spi_sclk_out) #1;
			got = {got[6:0], spi_mosi_out};
		end
		chk8(spi_select_n_out, 8'hfe);
		chk8(got, exp);
		settle(20);
		rd(ADDR_STATUS, v);
		chk8(v & 8'h01, 8'h00);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Cut a hang short; all frames together need well under this span.
	initial
	begin
		#300us;
		n_mismatch++;
		test_done();
	end

	initial
	begin
		settle(6);
		rst_in = 1'b0;
		rd(ADDR_CONTROL, v);
		chk8(v, 8'h00);
		rd(ADDR_STATUS, v);
		chk8(v, 8'h00);
		rd(10'h000, v);
		chk8(v, 8'h00);
		chk8(dio_oe_n_out[31:24], 8'hff);
		$display("test reset done");
		wr(ADDR_STATUS, 8'h30);
		frame(8'h26, 8'h40, 8'h0a, 8'h44);
		frame(8'h27, 8'h40, 8'h0a, 8'h44);
		rd(ADDR_STATUS, v);
		chk8(v, 8'h30);
		$display("test setup done");
		frame(8'h26, 8'h40, 8'h00, 8'h00);
		frame(8'h26, 8'h40, 8'h14, 8'h55);
		frame(8'h27, 8'h40, 8'h00, 8'h00);
		frame(8'h27, 8'h40, 8'h14, 8'ha5);
		frame(8'h27, 8'h40, 8'h06, 8'h0f);
		chk8(dio_out[7:0], 8'h55);
		chk8(dio_oe_n_out[7:0], 8'h00);
		chk8(dio_oe_n_out[15:8], 8'hff);
		chk8(dio_out[23:16], 8'ha0);
		chk8(dio_oe_n_out[23:16], 8'h05);
		$display("test outputs done");
		wr(ADDR_CONTROL, 8'h0b);
		chk8(spi_select_n_out, 8'hf7);
		wr(ADDR_CONTROL, 8'h03);
		chk8(spi_select_n_out, 8'hff);
		xmit(8'h32, 8'h1e, 8'h78);
		xmit(8'h30, 8'ha5, 8'ha5);
		$display("test serial done");
		ext_level[15:8] = 8'h3c;
		frame(8'h26, 8'h40, 8'h03, 8'hff);
		frame(8'h26, 8'h41, 8'h13, 8'h00);
		rd(ADDR_BYTE_ONE, v);
		chk8(v, 8'hc3);
		frame(8'h26, 8'h41, 8'h12, 8'h00);
		rd(ADDR_BYTE_ONE, v);
		chk8(v, 8'h55);
		$display("test inputs done");
		bus_irq_enable_in = 1'b1;
		wr(ADDR_STATUS, 8'h34);
		frame(8'h26, 8'h40, 8'h05, 8'h01);
		ext_level[8] = 1'b1;
		settle(10);
		chk8({5'h00, irq_out}, 8'h01);
		rd(ADDR_STATUS, v);
		chk8(v, 8'hb4);
		bus_irq_enable_in = 1'b0;
		settle(4);
		chk8({5'h00, irq_out}, 8'h00);
		bus_irq_enable_in = 1'b1;
		frame(8'h26, 8'h41, 8'h11, 8'h00);
		settle(4);
		chk8({5'h00, irq_out}, 8'h00);
		ext_level[8] = 1'b0;
		settle(10);
		chk8({5'h00, irq_out}, 8'h01);
		frame(8'h26, 8'h41, 8'h13, 8'h00);
		settle(4);
		chk8({5'h00, irq_out}, 8'h00);
		ext_irq_n_in = 1'b0;
		settle(10);
		chk8({5'h00, irq_out}, 8'h01);
		wr(ADDR_STATUS, 8'h38);
		settle(4);
		chk8({5'h00, irq_out}, 8'h02);
		ext_irq_n_in = 1'b1;
		settle(10);
		chk8({5'h00, irq_out}, 8'h00);
		$display("test interrupts done");
		test_done();
	end
endmodule
